// ===== rcps_bank.sv
/*
 regulator select registers, snapshot status register and interrupt logic on avalon-mm.
 assumes asynchronous status inputs from analog and loop logic, one 50 mhz clock.
*/
`timescale 1ns/100ps
`default_nettype none
`include "rcps_regs.svh"

// Operation
// - status register ignores writes to its own offset; only the update strobe changes it
// - channel bit set when all three loops lock
// - bit 2 shows calibration running
// - bit 1 shows stability timer verdict
// - bit 0 shows system loop lock
// - high register holds two select bits
module rcps_bank (
	input  wire logic        mclk,
	input  wire logic        nrst,
	input  wire logic [11:0] address,
	input  wire logic        read,
	input  wire logic        write,
	input  wire logic [31:0] writedata,
	output logic      [31:0] readdata,
	output logic             waitrequest,
	output logic             irq,
	output logic [9:0]       regulator_trim_select,
	input  wire logic        system_ref_clock_lock,
	input  wire logic        system_ref_clock_stable,
	input  wire logic        system_ref_clock_cal_busy,
	input  wire logic [3:0]  output_analog_loop_lock,
	input  wire logic [3:0]  digital_phase_loop_lock
);
	logic [10:0]         sync1_r;
	logic [10:0]         sync2_r;
	logic [7:0]          reg_low_r;
	logic [1:0]          reg_high_r;
	logic [7:0]          status_r;
	logic [7:0]          irq_stat_r;
	logic [7:0]          irq_mask_r;
	logic [7:0]          irq_stat_nxt;
	logic [31:0]         readdata_nxt;
	rcps_pkg::rcps_bus_t bus_r;
	wire                 req;
	wire                 take;
	wire                 wr_take;
	wire                 strobe;
	wire [7:0]           live;
	wire [7:0]           status_chg;
	wire                 hit_low;
	wire                 hit_high;
	wire                 hit_status;
	wire                 hit_upd;
	wire                 hit_istat;
	wire                 hit_imask;

	// one idle cycle of wait, then answer
	assign req         = read | write;
	assign take        = req & (bus_r == rcps_pkg::RCPS_DONE);
	assign waitrequest = req & (bus_r != rcps_pkg::RCPS_DONE);
	assign wr_take     = take & write;

	assign hit_low    = address == `RCPS_OFS_REG_LOW;
	assign hit_high   = address == `RCPS_OFS_REG_HIGH;
	assign hit_status = address == `RCPS_OFS_STATUS;
	assign hit_upd    = address == `RCPS_OFS_UPDATE;
	assign hit_istat  = address == `RCPS_OFS_IRQ_STAT;
	assign hit_imask  = address == `RCPS_OFS_IRQ_MASK;

	assign strobe = wr_take & hit_upd & (writedata[7:0] == `RCPS_UPDATE_CODE);

	// live status, synchronised inputs only
	assign live[`RCPS_ST_SYS_LOCK]   = sync2_r[0];
	assign live[`RCPS_ST_SYS_STABLE] = sync2_r[1];
	assign live[`RCPS_ST_CAL_BUSY]   = sync2_r[2];
	assign live[3]                   = 1'b0;
	assign live[7:4] = {4{sync2_r[0]}} & sync2_r[6:3] & sync2_r[10:7];

	assign status_chg = strobe ? (live ^ status_r) : 8'h00;
	assign irq_stat_nxt = (irq_stat_r & ~((wr_take & hit_istat) ? writedata[7:0] : 8'h00)) | status_chg;

	assign regulator_trim_select = {reg_high_r, reg_low_r};
	assign irq = |(irq_stat_r & irq_mask_r);

	always_comb begin
		readdata_nxt = 32'h0000_0000;
		if (hit_low) begin
			readdata_nxt = {24'h00_0000, reg_low_r};
		end else if (hit_high) begin
			readdata_nxt = {30'h0000_0000, reg_high_r};
		end else if (hit_status) begin
			readdata_nxt = {24'h00_0000, status_r};
		end else if (hit_istat) begin
			readdata_nxt = {24'h00_0000, irq_stat_r};
		end else if (hit_imask) begin
			readdata_nxt = {24'h00_0000, irq_mask_r};
		end
	end

	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			sync1_r <= 11'h000;
			sync2_r <= 11'h000;
		end else begin
			sync1_r <= {digital_phase_loop_lock, output_analog_loop_lock, system_ref_clock_cal_busy,
				system_ref_clock_stable, system_ref_clock_lock};
			sync2_r <= sync1_r;
		end
	end

	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			bus_r <= rcps_pkg::RCPS_IDLE;
		end else if (take || !req) begin
			bus_r <= rcps_pkg::RCPS_IDLE;
		end else begin
			bus_r <= rcps_pkg::RCPS_DONE;
		end
	end

	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			readdata <= 32'h0000_0000;
		end else if (req && !take) begin
			readdata <= readdata_nxt;
		end
	end

	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			reg_low_r  <= `RCPS_REG_LOW_RST;
			reg_high_r <= `RCPS_REG_HIGH_RST;
			irq_mask_r <= `RCPS_IRQ_RST;
		end else if (wr_take) begin
			if (hit_low) begin
				reg_low_r <= writedata[7:0];
			end
			if (hit_high) begin
				reg_high_r <= writedata[1:0];
			end
			if (hit_imask) begin
				irq_mask_r <= writedata[7:0];
			end
		end
	end

	// status changes only on the update strobe, never on other writes
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			status_r <= `RCPS_STATUS_RST;
		end else if (strobe) begin
			status_r <= live;
		end
	end

	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			irq_stat_r <= `RCPS_IRQ_RST;
		end else begin
			irq_stat_r <= irq_stat_nxt;
		end
	end

	a_status_holds: assert property (@(posedge mclk) disable iff (!nrst)
		!strobe |=> status_r == $past(status_r))
		else $error("status changed without update strobe");

	a_status_ro_write: assert property (@(posedge mclk) disable iff (!nrst)
		(wr_take && hit_status) |=> status_r == $past(status_r))
		else $error("status register took a write");

	a_snapshot_val: assert property (@(posedge mclk) disable iff (!nrst)
		strobe |=> status_r == $past(live))
		else $error("snapshot does not match live status");

	a_channel_lock: assert property (@(posedge mclk) disable iff (!nrst)
		strobe |=> status_r[7:4] == ($past(digital_phase_loop_lock, 3) & $past(output_analog_loop_lock, 3)
			& {4{$past(system_ref_clock_lock, 3)}}))
		else $error("channel lock bits wrong");

	a_cal_busy_bit: assert property (@(posedge mclk) disable iff (!nrst)
		strobe |=> status_r[2] == $past(system_ref_clock_cal_busy, 3))
		else $error("calibration bit wrong");

	a_stable_bit: assert property (@(posedge mclk) disable iff (!nrst)
		strobe |=> status_r[1] == $past(system_ref_clock_stable, 3))
		else $error("stable bit wrong");

	a_sys_lock_bit: assert property (@(posedge mclk) disable iff (!nrst)
		strobe |=> status_r[0] == $past(system_ref_clock_lock, 3) && status_r[3] == 1'b0)
		else $error("system lock bit wrong");

	a_high_write: assert property (@(posedge mclk) disable iff (!nrst)
		(wr_take && hit_high) |=> regulator_trim_select[9:8] == $past(writedata[1:0]))
		else $error("high select bits not stored");

	a_wait_answer: assert property (@(posedge mclk) disable iff (!nrst)
		($rose(req) && !take) |-> waitrequest ##1 !waitrequest)
		else $error("answer not one cycle after request");

	a_low_write: assert property (@(posedge mclk) disable iff (!nrst)
		(wr_take && hit_low) |=> regulator_trim_select[7:0] == $past(writedata[7:0]))
		else $error("low select bits not stored");

	a_low_hold: assert property (@(posedge mclk) disable iff (!nrst)
		!(wr_take && hit_low) |=> $stable(reg_low_r))
		else $error("low select bits changed without write");

	a_high_hold: assert property (@(posedge mclk) disable iff (!nrst)
		!(wr_take && hit_high) |=> $stable(reg_high_r))
		else $error("high select bits changed without write");

	a_mask_write: assert property (@(posedge mclk) disable iff (!nrst)
		(wr_take && hit_imask) |=> irq_mask_r == $past(writedata[7:0]))
		else $error("mask not stored");

	a_mask_hold: assert property (@(posedge mclk) disable iff (!nrst)
		!(wr_take && hit_imask) |=> $stable(irq_mask_r))
		else $error("mask changed without write");

	a_irq_set: assert property (@(posedge mclk) disable iff (!nrst)
		strobe |=> (irq_stat_r & $past(live ^ status_r)) == $past(live ^ status_r))
		else $error("status change did not set event bit");

	a_irq_clear: assert property (@(posedge mclk) disable iff (!nrst)
		(wr_take && hit_istat) |=> (irq_stat_r & $past(writedata[7:0])) == 8'h00)
		else $error("event bits not cleared by write of one");

	a_irq_hold: assert property (@(posedge mclk) disable iff (!nrst)
		(!strobe && !(wr_take && hit_istat)) |=> $stable(irq_stat_r))
		else $error("event bits changed without cause");

	a_irq_out_high: assert property (@(posedge mclk) disable iff (!nrst)
		((irq_stat_r & irq_mask_r) != 8'h00) |-> irq)
		else $error("interrupt low with unmasked event");

	a_irq_out_low: assert property (@(posedge mclk) disable iff (!nrst)
		((irq_stat_r & irq_mask_r) == 8'h00) |-> !irq)
		else $error("interrupt high with no unmasked event");

	a_wait_first: assert property (@(posedge mclk) disable iff (!nrst)
		(req && bus_r == rcps_pkg::RCPS_IDLE) |-> waitrequest)
		else $error("no wait in first request cycle");

	a_one_wait: assert property (@(posedge mclk) disable iff (!nrst)
		waitrequest |=> (!req || !waitrequest))
		else $error("more than one wait cycle");

	a_wait_idle: assert property (@(posedge mclk) disable iff (!nrst)
		!req |-> !waitrequest)
		else $error("wait raised without request");

	a_take_once: assert property (@(posedge mclk) disable iff (!nrst)
		take |=> !take)
		else $error("request taken twice");

	a_rd_status: assert property (@(posedge mclk) disable iff (!nrst)
		(take && read && hit_status) |-> readdata == {24'h00_0000, status_r})
		else $error("status read data wrong");

	a_rd_low: assert property (@(posedge mclk) disable iff (!nrst)
		(take && read && hit_low) |-> readdata == {24'h00_0000, reg_low_r})
		else $error("low select read data wrong");

	a_rd_high: assert property (@(posedge mclk) disable iff (!nrst)
		(take && read && hit_high) |-> readdata == {30'h0000_0000, reg_high_r})
		else $error("high select read data wrong");

	a_rd_irq: assert property (@(posedge mclk) disable iff (!nrst)
		(take && read && hit_istat) |-> readdata == {24'h00_0000, irq_stat_r})
		else $error("event read data wrong");

	a_rd_mask: assert property (@(posedge mclk) disable iff (!nrst)
		(take && read && hit_imask) |-> readdata == {24'h00_0000, irq_mask_r})
		else $error("mask read data wrong");

	a_rd_update: assert property (@(posedge mclk) disable iff (!nrst)
		(take && read && hit_upd) |-> readdata == 32'h0000_0000)
		else $error("update register read not zero");

	a_rd_unmapped: assert property (@(posedge mclk) disable iff (!nrst)
		(take && read && !(hit_low || hit_high || hit_status || hit_istat || hit_imask)) |->
			readdata == 32'h0000_0000)
		else $error("unmapped read not zero");

	a_wr_unmapped: assert property (@(posedge mclk) disable iff (!nrst)
		(wr_take && !(hit_low || hit_high || hit_imask)) |=> $stable({reg_low_r, reg_high_r, irq_mask_r}))
		else $error("write changed an unaddressed register");

	a_bit3_zero: assert property (@(posedge mclk) disable iff (!nrst)
		status_r[3] == 1'b0)
		else $error("reserved status bit set");

	a_status_no_bus: assert property (@(posedge mclk) disable iff (!nrst)
		(wr_take && !hit_upd) |=> $stable(status_r))
		else $error("status changed on other write");

	a_strobe_code: assert property (@(posedge mclk) disable iff (!nrst)
		(wr_take && hit_upd && writedata[7:0] != `RCPS_UPDATE_CODE) |=> $stable(status_r))
		else $error("status captured on wrong update code");
endmodule : rcps_bank
`default_nettype wire

// ===== rcps_bank_tb.sv
/*
 self-checking bench for rcps_bank: avalon master tasks, random snapshots, irq.
 assumes rcps_bank and rcps_regs.svh on the include path.
*/
`timescale 1ns/100ps
`default_nettype none
`include "rcps_regs.svh"
module rcps_bank_tb_top;
	logic        mclk = 0, nrst = 0, read = 0, write = 0, lk = 0, stb = 0, cal = 0;
	logic [11:0] address = 0;
	logic [31:0] writedata = 0;
	logic [3:0]  al = 0, dl = 0;
	wire  [31:0] readdata;
	wire         waitrequest, irq;
	wire  [9:0]  sel;
	int          miscompares = 0, tests_run = 0, i;
	logic [7:0]  lf = 8'h1b, q, e;
	logic [6:0]  v;
	logic [3:0]  w;
	always #10 mclk = ~mclk;
	rcps_bank dut (.mclk(mclk), .nrst(nrst), .address(address), .read(read), .write(write),
		.writedata(writedata), .readdata(readdata), .waitrequest(waitrequest), .irq(irq),
		.regulator_trim_select(sel), .system_ref_clock_lock(lk), .system_ref_clock_stable(stb),
		.system_ref_clock_cal_busy(cal), .output_analog_loop_lock(al), .digital_phase_loop_lock(dl));
	function automatic logic [7:0] lfsr(input logic [7:0] s);
		return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
	endfunction : lfsr
	function automatic logic [7:0] exp_st(input logic l, s, c, input logic [3:0] a, d);
		return {a & d & {4{l}}, 1'b0, c, s, l};
	endfunction : exp_st
	task stop_test;
		$display("checks %0d mismatches %0d", tests_run, miscompares);
		if (miscompares == 0 && tests_run > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : stop_test
	task check(input logic [31:0] seen, input logic [31:0] exp);
		tests_run++;
		if (seen !== exp) begin
			miscompares++;
			$display("mismatch at %0t: got %h expected %h", $time, seen, exp);
		end
	endtask : check
	task bus(input logic w, input logic [11:0] a, input logic [7:0] d);
		int n;
		n = 0;
		@(posedge mclk);
		address <= a; read <= !w; write <= w; writedata <= {24'h0, d};
		do begin
			@(posedge mclk);
			n++;
		end while (waitrequest !== 1'b0 && n < 20);
		if (waitrequest !== 1'b0) begin
			miscompares++;
			stop_test;
		end
		q = readdata[7:0];
		read <= 0;
		write <= 0;
	endtask : bus
	task rd(input logic [11:0] a, input logic [7:0] x);
		bus(1'b0, a, 8'h00);
		check({24'h0, q}, {24'h0, x});
	endtask : rd
	initial begin
		repeat (12) @(posedge mclk);
		nrst <= 1;
		rd(`RCPS_OFS_REG_LOW, 8'h00);
		rd(`RCPS_OFS_REG_HIGH, 8'h00);
		rd(`RCPS_OFS_STATUS, 8'h00);
		$display("reset values done");
		for (i = 0; i < 5; i++) begin
			lf = (i == 0) ? 8'hff : lfsr(lf);
			bus(1'b1, `RCPS_OFS_REG_LOW, lf);
			bus(1'b1, `RCPS_OFS_REG_HIGH, lf);
			rd(`RCPS_OFS_REG_LOW, lf);
			rd(`RCPS_OFS_REG_HIGH, {6'h0, lf[1:0]});
			check({22'h0, sel}, {22'h0, lf[1:0], lf});
		end
		$display("select registers done");
		bus(1'b1, `RCPS_OFS_STATUS, 8'hff);
		rd(`RCPS_OFS_STATUS, 8'h00);
		bus(1'b1, `RCPS_OFS_IRQ_MASK, 8'hff);
		for (i = 0; i < 10; i++) begin
			lf = lfsr(lf);
			v = (i == 0) ? 7'h7f : {lf[6:0]} | {6'h0, i[0]} << 2;
			lf = lfsr(lf);
			w = (i == 0) ? 4'hf : lf[3:0] | lf[7:4];
			e = exp_st(v[2], v[1], v[0], v[6:3], w);
			{al, lk, stb, cal} <= v;
			dl <= w;
			repeat (4) @(posedge mclk);
			bus(1'b1, `RCPS_OFS_UPDATE, `RCPS_UPDATE_CODE);
			{al, dl, lk, stb, cal} <= ~{al, dl, lk, stb, cal};
			rd(`RCPS_OFS_STATUS, e);
		end
		$display("status snapshots done");
		check({31'h0, irq}, 32'h1);
		bus(1'b1, `RCPS_OFS_IRQ_STAT, 8'hff);
		@(negedge mclk);
		check({31'h0, irq}, 32'h0);
		bus(1'b1, `RCPS_OFS_IRQ_MASK, 8'h00);
		repeat (4) @(posedge mclk);
		bus(1'b1, `RCPS_OFS_UPDATE, `RCPS_UPDATE_CODE);
		@(negedge mclk);
		check({31'h0, irq}, 32'h0);
		bus(1'b1, `RCPS_OFS_IRQ_MASK, 8'hff);
		@(negedge mclk);
		check({31'h0, irq}, 32'h1);
		rd(12'h123, 8'h00);
		rd(`RCPS_OFS_UPDATE, 8'h00);
		$display("irq and unmapped done");
		stop_test;
	end
endmodule : rcps_bank_tb_top
`default_nettype wire

// ===== rcps_pkg.sv
/*
 types for the regulator and loop status bank.
 assumes rcps_regs.svh is on the include path.
*/
`default_nettype none
package rcps_pkg;
	typedef enum logic [1:0] {
		RCPS_IDLE = 2'b00,
		RCPS_DONE = 2'b01
	} rcps_bus_t;
endpackage : rcps_pkg
`default_nettype wire

// ===== rcps_regs.svh
/*
 register offsets, field positions, reset values for the regulator and loop status bank.
 assumes inclusion by bare name from the testbench and the design module.
*/
`ifndef RCPS_REGS_SVH
`define RCPS_REGS_SVH
`define RCPS_OFS_REG_LOW    12'hb00
`define RCPS_OFS_REG_HIGH   12'hb01
`define RCPS_OFS_STATUS     12'hd01
`define RCPS_OFS_UPDATE     12'h00f
`define RCPS_OFS_IRQ_STAT   12'he00
`define RCPS_OFS_IRQ_MASK   12'he01
`define RCPS_UPDATE_CODE    8'h01
`define RCPS_REG_LOW_RST    8'h00
`define RCPS_REG_HIGH_RST   2'h0
`define RCPS_ST_SYS_LOCK    0
`define RCPS_ST_SYS_STABLE  1
`define RCPS_ST_CAL_BUSY    2
`define RCPS_ST_CH_BASE     4
`define RCPS_STATUS_RST     8'h00
`define RCPS_IRQ_RST        8'h00
`endif
